/* File: verilog/sep_pkg.sv */
// shared types and constants of the protected sram controller
package sep_pkg;

    // address windows of the main bank and the standby bank
    localparam logic [31:0] SEP_ECC_WIN_BASE   = 32'h2000_0000;
    localparam logic [31:0] SEP_PLAIN_WIN_BASE = 32'h2001_0000;
    localparam logic [31:0] SEP_STBY_BASE      = 32'h2800_0000;
    localparam int          SEP_WIN_SHIFT      = 16;

    // sizes in 32-bit words
    localparam int SEP_BANK_WORDS = 16384;
    localparam int SEP_ECC_WORDS  = 8192;
    localparam int SEP_STBY_WORDS = 256;

    // stored word layout: data in the low bits, check bits above
    localparam int SEP_DATA_W = 32;
    localparam int SEP_HAM_W  = 6;
    localparam int SEP_CHK_W  = 7;
    localparam int SEP_PAR_W  = 4;
    localparam int SEP_WORD_W = SEP_DATA_W + SEP_CHK_W;
    localparam int SEP_HAM_POSITIONS = SEP_DATA_W + SEP_CHK_W;

    // standby power-cut setting that keeps the standby bank powered
    localparam logic [1:0] SEP_CUT_KEEP = 2'h0;

    // wait setting after reset: one wait state
    localparam logic SEP_WAIT_RESET = 1'h1;

    typedef enum logic [2:0] {
        SEP_S_IDLE = 3'h1,
        SEP_S_WAIT = 3'h2,
        SEP_S_DONE = 3'h4
    } sep_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  be;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sep_req_t;

    typedef struct packed {
        logic        done;
        logic        err;
        logic [31:0] rdata;
    } sep_rsp_t;

    localparam sep_req_t SEP_REQ_NONE = '0;
    localparam sep_rsp_t SEP_RSP_NONE = '0;

endpackage

/* File: verilog/sep_sram_ctrl.sv */
// protected on-chip sram controller: secded low area, byte parity elsewhere
module sep_sram_ctrl
    import sep_pkg::*;
#(
    parameter int BANK_WORDS = SEP_BANK_WORDS,
    parameter int ECC_WORDS  = SEP_ECC_WORDS,
    parameter int STBY_WORDS = SEP_STBY_WORDS
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire sep_req_t   req,
    input  wire logic       zero_wait_sel,
    input  wire logic       module_stop,
    input  wire logic       deep_standby,
    input  wire logic [1:0] standby_power_cut_field,
    output sep_rsp_t        rsp,
    output logic            mem_err_evt,
    output logic            stop_ack
);

    localparam int OFF_W  = $clog2(BANK_WORDS);
    localparam int MAIN_W = OFF_W + 1;
    localparam int STBY_W = $clog2(STBY_WORDS);
    localparam int MAIN_N = 2 * BANK_WORDS;

    // secded generator: hamming bits over positions 1..38, then overall parity
    function automatic logic [SEP_CHK_W-1:0] ecc_gen(
        input logic [SEP_DATA_W-1:0] d
    );
        logic [SEP_HAM_W-1:0] h;
        int                   k;
        h = '0;
        k = 0;
        for (int pos = 1; pos < SEP_HAM_POSITIONS; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                if (d[k]) begin
                    h = h ^ SEP_HAM_W'(pos);
                end
                k++;
            end
        end
        return {(^d) ^ (^h), h};
    endfunction

    // flips the data bit whose code position equals the syndrome
    function automatic logic [SEP_DATA_W-1:0] ecc_fix(
        input logic [SEP_DATA_W-1:0] d,
        input logic [SEP_HAM_W-1:0]  syn
    );
        logic [SEP_DATA_W-1:0] r;
        int                    k;
        r = d;
        k = 0;
        for (int pos = 1; pos < SEP_HAM_POSITIONS; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                if (SEP_HAM_W'(pos) == syn) begin
                    r[k] = ~d[k];
                end
                k++;
            end
        end
        return r;
    endfunction

    function automatic logic [SEP_PAR_W-1:0] par_gen(
        input logic [SEP_DATA_W-1:0] d
    );
        logic [SEP_PAR_W-1:0] p;
        p = '0;
        for (int b = 0; b < SEP_PAR_W; b++) begin
            p[b] = ^d[b*8 +: 8];
        end
        return p;
    endfunction

    sep_state_t                state_q;
    sep_state_t                state_d;
    sep_req_t                  req_q;
    sep_rsp_t                  rsp_q;
    logic                      err_evt_q;
    logic                      stop_ack_q;
    logic                      wait_one_q;
    logic [SEP_WORD_W-1:0]     main_mem [MAIN_N];
    logic [SEP_DATA_W+SEP_PAR_W-1:0] stby_mem [STBY_WORDS];

    // an access runs either straight from idle or after the wait cycle
    wire       is_idle   = (state_q == SEP_S_IDLE);
    wire       is_wait   = (state_q == SEP_S_WAIT);
    // rule 9: no request is taken while stopped or in deep standby
    // stop gating
    wire       halted    = module_stop | deep_standby;
    wire       accept    = is_idle & req.valid & ~halted;
    wire       go_now    = accept & ~wait_one_q;
    wire       do_access = go_now | is_wait;
    sep_req_t  act;
    assign act = is_wait ? req_q : req;

    wire       in_ecc_win   = act.addr[31:SEP_WIN_SHIFT]
                              == SEP_ECC_WIN_BASE[31:SEP_WIN_SHIFT];
    wire       in_plain_win = act.addr[31:SEP_WIN_SHIFT]
                              == SEP_PLAIN_WIN_BASE[31:SEP_WIN_SHIFT];
    wire [13:0] word_off    = act.addr[15:2];
    wire       off_ok       = 32'(word_off) < 32'(BANK_WORDS);
    wire       hit_main     = (in_ecc_win | in_plain_win) & off_ok;
    wire [31:0] stby_off    = act.addr - SEP_STBY_BASE;
    wire       hit_stby     = stby_off < 32'(STBY_WORDS * 4);
    wire       use_ecc      = in_ecc_win & (32'(word_off) < 32'(ECC_WORDS));
    wire [MAIN_W-1:0] midx  = {in_plain_win, word_off[OFF_W-1:0]};
    wire [STBY_W-1:0] sidx  = stby_off[STBY_W+1:2];

    // stored word as read, standby words widened with zero check bits
    wire [SEP_WORD_W-1:0] raw = hit_stby
        ? {{(SEP_CHK_W-SEP_PAR_W){1'b0}}, stby_mem[sidx]}
        : main_mem[midx];
    wire [SEP_DATA_W-1:0] raw_d = raw[SEP_DATA_W-1:0];
    wire [SEP_CHK_W-1:0]  raw_c = raw[SEP_WORD_W-1:SEP_DATA_W];

    wire [SEP_CHK_W-1:0] chk_calc = ecc_gen(raw_d);
    wire [SEP_HAM_W-1:0] syn      = chk_calc[SEP_HAM_W-1:0]
                                    ^ raw_c[SEP_HAM_W-1:0];
    wire                 ovl_bad  = ^{raw_d, raw_c};
    wire                 dbl_err  = (syn != '0) & ~ovl_bad;
    wire [SEP_DATA_W-1:0] ecc_d   = ecc_fix(raw_d, syn);
    wire                 par_err  = par_gen(raw_d) != raw_c[SEP_PAR_W-1:0];

    wire                 mem_err  = use_ecc ? dbl_err : par_err;
    wire [SEP_DATA_W-1:0] good_d  = use_ecc ? ecc_d : raw_d;
    wire                 hit      = hit_main | hit_stby;
    // partial writes merge into the corrected word; a read check is needed
    wire                 partial  = act.write & (act.be != 4'hf);
    wire                 chk_evt  = do_access & hit & (~act.write | partial)
                                    & mem_err;

    logic [SEP_DATA_W-1:0] merged;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            merged[b*8 +: 8] = act.be[b] ? act.wdata[b*8 +: 8]
                                         : good_d[b*8 +: 8];
        end
    end

    wire [SEP_CHK_W-1:0] new_chk = use_ecc
        ? ecc_gen(merged)
        : {{(SEP_CHK_W-SEP_PAR_W){1'b0}}, par_gen(merged)};
    // an uncorrectable merge is dropped rather than written back coded-clean
    wire wr_ok   = do_access & act.write & ~chk_evt;
    wire wr_main = wr_ok & hit_main;
    wire wr_stby = wr_ok & hit_stby;
    wire stby_lost = deep_standby & (standby_power_cut_field != SEP_CUT_KEEP);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SEP_S_IDLE: begin
                if (accept) begin
                    state_d = wait_one_q ? SEP_S_WAIT : SEP_S_DONE;
                end
            end
            SEP_S_WAIT: state_d = SEP_S_DONE;
            SEP_S_DONE: state_d = SEP_S_IDLE;
            default:    state_d = SEP_S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= SEP_S_IDLE;
            req_q   <= SEP_REQ_NONE;
        end else begin
            state_q <= state_d;
            if (accept) begin
                req_q <= req;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wait_one_q <= SEP_WAIT_RESET;
        end else if (is_idle) begin
            wait_one_q <= ~zero_wait_sel;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rsp_q      <= SEP_RSP_NONE;
            err_evt_q  <= 1'b0;
            stop_ack_q <= 1'b0;
        end else begin
            rsp_q.done  <= do_access;
            rsp_q.err   <= do_access & (~hit | chk_evt);
            rsp_q.rdata <= (do_access & hit & ~act.write) ? good_d : '0;
            err_evt_q   <= chk_evt;
            stop_ack_q  <= halted & is_idle;
        end
    end

    // storage holds no reset value; contents are undefined until written or zeroed by deep standby, the standby bank only when its power is cut
    always_ff @(posedge clk_sys) begin
        if (deep_standby) begin
            for (int i = 0; i < MAIN_N; i++) begin
                main_mem[i] <= '0;
            end
        end else if (wr_main) begin
            main_mem[midx] <= {new_chk, merged};
        end
        if (stby_lost) begin
            for (int i = 0; i < STBY_WORDS; i++) begin
                stby_mem[i] <= '0;
            end
        end else if (wr_stby) begin
            stby_mem[sidx] <= {new_chk[SEP_PAR_W-1:0], merged};
        end
    end

    assign rsp         = rsp_q;
    assign mem_err_evt = err_evt_q;
    assign stop_ack    = stop_ack_q;

endmodule

/* File: tb/sep_ctrl_properties.sv */
// port assertions of the protected sram controller
module sep_ctrl_properties
    import sep_pkg::*;
#(
    parameter int BANK_WORDS = SEP_BANK_WORDS,
    parameter int STBY_WORDS = SEP_STBY_WORDS
) (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire sep_req_t   req,
    input wire logic       zero_wait_sel,
    input wire logic       module_stop,
    input wire logic       deep_standby,
    input wire logic [1:0] standby_power_cut_field,
    input wire sep_rsp_t   rsp,
    input wire logic       mem_err_evt,
    input wire logic       stop_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_q;
    logic busy_d;
    wire  take = !busy_q && req.valid && !module_stop && !deep_standby;
    wire  in_main = req.addr[31:17] == 15'h1000;
    wire  in_stby = req.addr[31:16] == 16'h2800;
    wire  mapped = (in_main && req.addr[15:2] < BANK_WORDS) ||
                   (in_stby && req.addr[15:2] < STBY_WORDS);
    // a request counts as outstanding until its done pulse
    assign busy_d = take ? 1'h1 : (rsp.done ? 1'h0 : busy_q);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'h0;
        end else begin
            busy_q <= busy_d;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_zero_wait:
        assert property (take && zero_wait_sel && $past(zero_wait_sel)
            |=> rsp.done) else $error("zero wait answer not next cycle");
    a_one_wait:
        assert property (take && !zero_wait_sel && !$past(zero_wait_sel)
            |=> !rsp.done ##1 rsp.done) else $error("one wait answer off");
    a_done_pulse:
        assert property (rsp.done |=> !rsp.done) else $error("long done");
    a_event_err:
        assert property (mem_err_evt |-> rsp.done && rsp.err)
            else $error("event without erroneous done");
    a_unmapped_err:
        assert property (take && !mapped
            |-> ##[1:2] (rsp.done && rsp.err && !mem_err_evt))
            else $error("unmapped access not refused");
    a_full_write:
        assert property (take && mapped && req.write && req.be == 4'hf
            |-> ##[1:2] (rsp.done && !rsp.err))
            else $error("full word write failed");
    a_stop_ack:
        assert property (module_stop [*5] |-> stop_ack)
            else $error("stop not acknowledged");
    a_stop_hold:
        assert property (stop_ack && module_stop |=> !rsp.done)
            else $error("answer while stopped");
    a_standby_hold:
        assert property (deep_standby && !busy_q |=> !rsp.done)
            else $error("answer in deep standby");
endmodule

bind sep_sram_ctrl sep_ctrl_properties #(
    .BANK_WORDS(BANK_WORDS), .STBY_WORDS(STBY_WORDS)
) sep_ctrl_properties_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .req(req),
    .zero_wait_sel(zero_wait_sel), .module_stop(module_stop),
    .deep_standby(deep_standby),
    .standby_power_cut_field(standby_power_cut_field),
    .rsp(rsp), .mem_err_evt(mem_err_evt), .stop_ack(stop_ack)
);

/* File: tb/sep_master_model.sv */
// bus master model: holds each request until its answer comes or 40 cycles pass
module sep_master_model
    import sep_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire sep_rsp_t rsp,
    output sep_req_t      req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = SEP_REQ_NONE;
    task automatic access(input logic wr, input logic [3:0] be,
            input logic [31:0] a, input logic [31:0] d,
            output sep_rsp_t r, output int n);
        n = 0;
        r = SEP_RSP_NONE;
        @(negedge clk_sys);
        req = '{valid: 1'h1, write: wr, be: be, addr: a, wdata: d};
        // answer taken at the very edge that samples done high
        do begin
            @(posedge clk_sys);
            n++;
            r = rsp;
        end while (!r.done && n < 40);
        @(negedge clk_sys);
        // released lines show the inverse, never the last value
        req = '{valid: 1'h0, write: ~wr, be: ~be, addr: ~a, wdata: ~d};
    endtask
endmodule

/* File: tb/sep_sram_ctrl_tb_top.sv */
// self-checking bench of the protected sram controller
module sep_sram_ctrl_tb_top
    import sep_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst_b = 0, zero_wait_sel = 0;
    logic module_stop = 0, deep_standby = 0, mem_err_evt, stop_ack;
    logic [1:0] standby_power_cut_field = 2'h0;
    sep_req_t req;
    sep_rsp_t rsp, r;
    int n, fail_count = 0, comparisons = 0;
    int evt_count = 0;
    // small banks keep the run short: 64 main, 32 coded, 16 standby words
    sep_sram_ctrl #(.BANK_WORDS(64), .ECC_WORDS(32), .STBY_WORDS(16))
    sep_sram_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b), .req(req),
        .zero_wait_sel(zero_wait_sel), .module_stop(module_stop),
        .deep_standby(deep_standby), .rsp(rsp), .stop_ack(stop_ack),
        .standby_power_cut_field(standby_power_cut_field),
        .mem_err_evt(mem_err_evt));
    sep_master_model sep_master_model_inst (.clk_sys(clk_sys),
        .rsp(rsp), .req(req));
    always #20 clk_sys = ~clk_sys;
    // error event pulses, counted where they stand
    always @(posedge clk_sys) begin
        if (mem_err_evt === 1'b1) begin
            evt_count <= evt_count + 1;
        end
    end
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic go(input logic w, input logic [3:0] be,
            input logic [31:0] a, input logic [31:0] d);
        sep_master_model_inst.access(w, be, a, d, r, n);
    endtask
    task automatic wr(input logic [3:0] be, input logic [31:0] a, d);
        go(1'h1, be, a, d);
        check("write ok", {r.done, r.err}, 32'h2);
    endtask
    task automatic rd(input logic [31:0] a, exp);
        go(1'h0, 4'hf, a, 32'h0);
        check("read ok", {r.done, r.err}, 32'h2);
        check("rdata", r.rdata, exp);
    endtask
    task automatic t_windows;
        wr(4'hf, 32'h2000_0000, 32'h1111_2222);
        check("one wait", n, 32'h3);
        wr(4'hf, 32'h2001_0000, 32'h3333_4444);
        wr(4'hf, 32'h2000_00a0, 32'h5555_6666);
        rd(32'h2000_0000, 32'h1111_2222);
        rd(32'h2001_0000, 32'h3333_4444);
        rd(32'h2000_00a0, 32'h5555_6666);
    endtask
    task automatic t_zero_wait;
        zero_wait_sel = 1'h1;
        repeat (2) @(negedge clk_sys);
        wr(4'hf, 32'h2800_0004, 32'h0f0f_a5a5);
        check("zero wait", n, 32'h2);
        rd(32'h2800_0004, 32'h0f0f_a5a5);
        zero_wait_sel = 1'h0;
    endtask
    task automatic t_bytes;
        wr(4'hf, 32'h2001_0008, 32'haabb_ccdd);
        wr(4'h5, 32'h2001_0008, 32'h1122_3344);
        rd(32'h2001_0008, 32'haa22_cc44);
        wr(4'hf, 32'h2000_0010, 32'h0102_0304);
        wr(4'ha, 32'h2000_0010, 32'hf0e0_d0c0);
        rd(32'h2000_0010, 32'hf002_d004);
        check("no event", evt_count, 32'h0);
    endtask
    task automatic t_unmapped;
        go(1'h0, 4'hf, 32'h2000_0100, 32'h0);
        check("gap err", {r.done, r.err}, 32'h3);
        go(1'h1, 4'hf, 32'h3000_0000, 32'h1);
        check("far err", {r.done, r.err}, 32'h3);
        check("unmapped event", evt_count, 32'h0);
    endtask
    task automatic t_stop;
        module_stop = 1'h1;
        fork
            go(1'h0, 4'hf, 32'h2001_0000, 32'h0);
            begin
                repeat (6) @(negedge clk_sys);
                check("stop_ack", stop_ack, 32'h1);
                module_stop = 1'h0;
            end
        join
        check("late rdata", r.rdata, 32'h3333_4444);
    endtask
    task automatic ds_pulse(input logic [1:0] cut);
        @(negedge clk_sys);
        standby_power_cut_field = cut;
        deep_standby = 1'h1;
        repeat (3) @(negedge clk_sys);
        deep_standby = 1'h0;
    endtask
    task automatic t_standby;
        wr(4'hf, 32'h2800_0000, 32'h1234_5678);
        ds_pulse(2'h0);
        rd(32'h2000_0000, 32'h0);
        rd(32'h2800_0000, 32'h1234_5678);
        ds_pulse(2'h1);
        rd(32'h2800_0000, 32'h0);
    endtask
    task automatic stop_test;
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk_sys);
        rst_b = 1'h1;
        t_windows();
        t_zero_wait();
        t_bytes();
        t_unmapped();
        t_stop();
        t_standby();
        stop_test();
    end
    // the scenarios need about a hundred cycles; 5000 means a hang
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
endmodule
